// ---- vot_consts.vh ----
// constants for the video output timing and transfer block
`ifndef VOT_CONSTS_VH
`define VOT_CONSTS_VH
// register byte addresses
`define VOT_A_CTL 8'h00
`define VOT_A_FRAME 8'h04
`define VOT_A_LINE 8'h08
`define VOT_A_FIELD 8'h0C
`define VOT_A_LOCK 8'h10
`define VOT_A_DATA 8'h14
`define VOT_A_MSG 8'h18
`define VOT_A_MLEN 8'h1C
`define VOT_A_STAT 8'h20
`define VOT_A_IMG 8'h24
`define VOT_A_CSIZE 8'h28
`define VOT_A_OVW 8'h2C
// video_out_control bits
`define VOT_C_EN 0
`define VOT_C_MASTER 1
`define VOT_C_XLOCK 2
`define VOT_C_POL 3
`define VOT_C_FSYNC 4
`define VOT_C_SSTRM 5
`define VOT_C_RUN 10
`define VOT_C_MODE_HI 9
`define VOT_C_MODE_LO 8
// modes
`define VOT_M_REFRESH 2'h0
`define VOT_M_STREAM 2'h1
`define VOT_M_MSG 2'h2
// status bits
`define VOT_S_EMPTY 0
`define VOT_S_BWERR 1
`define VOT_S_RESYNC 2
`define VOT_S_FULL 3
`define VOT_S_LOCKED 4
`define VOT_S_FIELD 5
// reset values
`define VOT_R_CTL 11'h000
`define VOT_R_LTOT 10'h20D
`define VOT_R_PRESET 10'h002
`define VOT_R_PTOT 12'h6B4
`define VOT_R_ACT 12'h114
`define VOT_R_F2 10'h10A
`define VOT_R_LOCK 16'h0000
// sync code bytes
`define VOT_PRE0 8'hFF
`define VOT_PRE1 8'h00
`define VOT_BLK_C 8'h80
`define VOT_BLK_Y 8'h10
`endif

// ---- vot_video_out.v ----
// video output unit: sync timing, external lock and byte transfer control
`timescale 1ns/1ps
`include "vot_consts.vh"
module vot_video_out #(
  parameter MSG_DEPTH = 16,
  parameter MSG_AW = 4
) (
  input wire i_ref_clk, // 25 MHz block clock
  input wire i_rst, // synchronous reset, high
  input wire [7:0] i_addr, // register byte address
  input wire [31:0] i_wdata, // register write data
  input wire i_wr, // write strobe
  input wire i_rd, // read strobe
  output reg [31:0] o_rdata, // read data, cycle after strobe
  input wire i_video_clk, // video output clock, sampled
  input wire i_frame_pin_i, // frame timing pin level in
  output reg o_frame_pin_o, // frame timing pin drive
  output reg o_frame_pin_oe, // frame timing pin enable
  output reg o_line_pin, // line timing pin
  output reg [7:0] o_byte, // video byte bus
  output reg o_msg_done // first buffer empty, to host
);
  localparam D_IDLE = 2'h0;
  localparam D_START = 2'h1;
  localparam D_SEND = 2'h2;
  localparam D_END = 2'h3;

  // protected sync code: 1 F V H P3 P2 P1 P0
  function [7:0] vot_xy;
    input f;
    input v;
    input h;
    begin
      vot_xy = {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h};
    end
  endfunction

  // bytes in one chroma plane, 4:2:0 halves the lines too
  function [31:0] vot_chroma;
    input [11:0] w;
    input [11:0] h;
    input is420;
    begin
      if (is420)
        vot_chroma = {21'h000000, w[11:1]} * {21'h000000, h[11:1]};
      else
        vot_chroma = {21'h000000, w[11:1]} * {20'h00000, h};
    end
  endfunction

  reg vclk_s1, vclk_s2, vclk_s3;
  reg fp_s1, fp_s2, fp_s3;
  reg [10:0] ctl;
  reg [9:0] ltot, preset, f2_start;
  reg [11:0] ptot, act;
  reg [15:0] lock_dly, dcnt;
  reg [11:0] img_w, img_h, ov_w;
  reg img_420;
  reg [7:0] hold;
  reg hold_full;
  reg [7:0] msg_mem [0:MSG_DEPTH-1];
  reg [MSG_AW-1:0] wr_idx, rd_idx;
  reg [MSG_AW:0] msg_len;
  reg [11:0] pix;
  reg [9:0] line;
  reg field;
  reg pending, locked, resync, bw_err, empty;
  reg [1:0] dstate;
  reg [7:0] next_byte;

  wire en = ctl[`VOT_C_EN];
  wire master = ctl[`VOT_C_MASTER];
  wire [1:0] mode = ctl[`VOT_C_MODE_HI:`VOT_C_MODE_LO];
  wire run = ctl[`VOT_C_RUN];
  wire refresh = en && (mode == `VOT_M_REFRESH);
  wire xlock = refresh && !master && ctl[`VOT_C_XLOCK];
  // one-cycle enable at each rising edge of the video clock
  wire ven = vclk_s2 && !vclk_s3;
  wire fedge = ctl[`VOT_C_POL] ? (fp_s2 && !fp_s3) :
    (!fp_s2 && fp_s3);
  wire pix_end = (pix == ptot - 12'h001);
  wire [11:0] pix_nx = pix_end ? 12'h000 : pix + 12'h001;
  wire [9:0] line_nx = !pix_end ? line :
    ((line >= ltot) ? 10'h001 : line + 10'h001);
  wire fire = xlock && pending && ven && (dcnt == 16'h0000);
  wire predicted = locked && (pix_nx == 12'h000) && (line_nx == preset);
  wire cur_field = (line >= f2_start);
  wire in_blank = (pix < act);
  wire [7:0] stat = {2'b00, field, locked, hold_full, resync, bw_err, empty};

  // sync-code and blanking byte for the current position
  always @* begin
    next_byte = pix[0] ? `VOT_BLK_Y : `VOT_BLK_C;
    if (pix < 12'h004 || (pix >= act - 12'h004 && pix < act)) begin
      case (pix[1:0])
        2'h0: next_byte = `VOT_PRE0;
        2'h3: next_byte = vot_xy(cur_field, 1'b0, pix < 12'h004);
        default: next_byte = `VOT_PRE1;
      endcase
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      vclk_s1 <= 1'b0;
      vclk_s2 <= 1'b0;
      vclk_s3 <= 1'b0;
      fp_s1 <= 1'b0;
      fp_s2 <= 1'b0;
      fp_s3 <= 1'b0;
    end else begin
      vclk_s1 <= i_video_clk;
      vclk_s2 <= vclk_s1;
      vclk_s3 <= vclk_s2;
      fp_s1 <= i_frame_pin_i;
      fp_s2 <= fp_s1;
      fp_s3 <= fp_s2;
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_rdata <= 32'h00000000;
    end else if (i_rd) begin
      case (i_addr)
        `VOT_A_CTL: o_rdata <= {21'h000000, ctl};
        `VOT_A_FRAME: o_rdata <= {6'h00, preset, 6'h00, ltot};
        `VOT_A_LINE: o_rdata <= {4'h0, act, 4'h0, ptot};
        `VOT_A_FIELD: o_rdata <= {22'h000000, f2_start};
        `VOT_A_LOCK: o_rdata <= {16'h0000, lock_dly};
        `VOT_A_MLEN: o_rdata <= {{(31-MSG_AW){1'b0}}, msg_len};
        `VOT_A_STAT: o_rdata <= {6'h00, line, 8'h00, stat};
        `VOT_A_IMG: o_rdata <= {3'h0, img_420, img_h, 4'h0, img_w};
        `VOT_A_CSIZE: o_rdata <= vot_chroma(img_w, img_h, img_420);
        `VOT_A_OVW: o_rdata <= {18'h00000, ov_w, 2'h0};
        default: o_rdata <= 32'h00000000;
      endcase
    end else begin
      o_rdata <= 32'h00000000;
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      ctl <= `VOT_R_CTL;
      ltot <= `VOT_R_LTOT;
      preset <= `VOT_R_PRESET;
      ptot <= `VOT_R_PTOT;
      act <= `VOT_R_ACT;
      f2_start <= `VOT_R_F2;
      lock_dly <= `VOT_R_LOCK;
      dcnt <= 16'h0000;
      img_w <= 12'h000;
      img_h <= 12'h000;
      img_420 <= 1'b0;
      ov_w <= 12'h000;
      hold <= 8'h00;
      hold_full <= 1'b0;
      wr_idx <= {MSG_AW{1'b0}};
      rd_idx <= {MSG_AW{1'b0}};
      msg_len <= {(MSG_AW+1){1'b0}};
      pix <= 12'h000;
      line <= 10'h001;
      field <= 1'b0;
      pending <= 1'b0;
      locked <= 1'b0;
      resync <= 1'b0;
      bw_err <= 1'b0;
      empty <= 1'b0;
      dstate <= D_IDLE;
      o_frame_pin_o <= 1'b0;
      o_frame_pin_oe <= 1'b0;
      o_line_pin <= 1'b1;
      o_byte <= 8'h00;
      o_msg_done <= 1'b0;
    end else begin
      // frame pin is an input only in video refresh mode with the block not timing master
      o_frame_pin_oe <= !(refresh && !master);
      o_msg_done <= empty;
      if (!refresh) begin
        pix <= 12'h000;
        line <= 10'h001;
        pending <= 1'b0;
        locked <= 1'b0;
      end
      if (!en) begin
        o_line_pin <= 1'b1;
        o_frame_pin_o <= 1'b0;
        o_byte <= 8'h00;
        dstate <= D_IDLE;
      end
      if (!xlock) begin
        pending <= 1'b0;
        locked <= 1'b0;
      end else if (fedge) begin
        pending <= 1'b1;
        dcnt <= lock_dly;
      end else if (ven && pending && dcnt != 16'h0000) begin
        dcnt <= dcnt - 16'h0001;
      end
      // video refresh: free run, or realign on a delayed frame edge
      if (refresh && ven) begin
        o_byte <= next_byte;
        o_line_pin <= !in_blank;
        if (pix == 12'h000)
          field <= cur_field;
        if (master && ctl[`VOT_C_FSYNC])
          o_frame_pin_o <= (pix == 12'h000) ? cur_field : field;
        else if (master)
          o_frame_pin_o <= (line == 10'h001);
        else
          o_frame_pin_o <= 1'b0;
        if (fire) begin
          pending <= 1'b0;
          locked <= 1'b1;
          pix <= 12'h000;
          line <= preset;
          if (!predicted)
            resync <= 1'b1;
        end else begin
          pix <= pix_nx;
          line <= line_nx;
        end
      end
      // data transfer modes, one byte per video clock
      if (en && mode == `VOT_M_STREAM && ven) begin
        case (dstate)
          D_IDLE: begin
            o_line_pin <= 1'b0;
            o_frame_pin_o <= 1'b0;
            if (run && hold_full) begin
              o_line_pin <= 1'b1;
              dstate <= D_START;
            end
          end
          D_START: begin
            o_line_pin <= 1'b0;
            o_byte <= hold;
            hold_full <= 1'b0;
            o_frame_pin_o <= ctl[`VOT_C_SSTRM];
            dstate <= D_SEND;
          end
          D_SEND: begin
            if (!run) begin
              o_frame_pin_o <= 1'b0;
              dstate <= D_IDLE;
            end else if (hold_full) begin
              o_byte <= hold;
              hold_full <= 1'b0;
            end else begin
              bw_err <= 1'b1;
              o_frame_pin_o <= 1'b0;
              dstate <= D_IDLE;
            end
          end
          default: dstate <= D_IDLE;
        endcase
      end
      if (en && mode == `VOT_M_MSG && ven) begin
        case (dstate)
          D_IDLE: begin
            o_line_pin <= 1'b0;
            o_frame_pin_o <= 1'b0;
            rd_idx <= {MSG_AW{1'b0}};
            if (run) begin
              o_line_pin <= 1'b1;
              dstate <= D_START;
            end
          end
          D_START: begin
            o_line_pin <= 1'b0;
            dstate <= (msg_len == {(MSG_AW+1){1'b0}}) ? D_END : D_SEND;
          end
          D_SEND: begin
            o_byte <= msg_mem[rd_idx];
            rd_idx <= rd_idx + {{(MSG_AW-1){1'b0}}, 1'b1};
            if ({1'b0, rd_idx} + {{MSG_AW{1'b0}}, 1'b1} >= msg_len)
              dstate <= D_END;
          end
          D_END: begin
            o_frame_pin_o <= 1'b1;
            ctl[`VOT_C_RUN] <= 1'b0;
            dstate <= D_IDLE;
          end
          default: dstate <= D_IDLE;
        endcase
      end
      // software writes come after hardware clears so a new run wins
      if (i_wr) begin
        case (i_addr)
          `VOT_A_CTL: ctl <= i_wdata[10:0];
          `VOT_A_FRAME: begin
            ltot <= i_wdata[9:0];
            preset <= i_wdata[25:16];
          end
          `VOT_A_LINE: begin
            ptot <= i_wdata[11:0];
            act <= i_wdata[27:16];
          end
          `VOT_A_FIELD: f2_start <= i_wdata[9:0];
          `VOT_A_LOCK: lock_dly <= i_wdata[15:0];
          `VOT_A_DATA: begin
            hold <= i_wdata[7:0];
            hold_full <= 1'b1;
          end
          `VOT_A_MSG: begin
            msg_mem[wr_idx] <= i_wdata[7:0];
            wr_idx <= wr_idx + {{(MSG_AW-1){1'b0}}, 1'b1};
          end
          `VOT_A_MLEN: begin
            msg_len <= i_wdata[MSG_AW:0];
            wr_idx <= {MSG_AW{1'b0}};
          end
          `VOT_A_STAT: begin
            if (i_wdata[`VOT_S_EMPTY])
              empty <= 1'b0;
            if (i_wdata[`VOT_S_BWERR])
              bw_err <= 1'b0;
            if (i_wdata[`VOT_S_RESYNC])
              resync <= 1'b0;
          end
          `VOT_A_IMG: begin
            img_w <= i_wdata[11:0];
            img_h <= i_wdata[27:16];
            img_420 <= i_wdata[28];
          end
          `VOT_A_OVW: ov_w <= i_wdata[12:1];
          default: ;
        endcase
      end
      // hardware sets after the software clear, so the set wins
      if (en && mode == `VOT_M_MSG && ven && dstate == D_END)
        empty <= 1'b1;
      if (en && mode == `VOT_M_STREAM && ven && dstate == D_SEND &&
          run && !hold_full)
        bw_err <= 1'b1;
      if (fire && !predicted)
        resync <= 1'b1;
      if (i_wr && i_addr == `VOT_A_DATA)
        hold_full <= 1'b1;
    end
  end
endmodule

// ---- vot_video_out_asserts.sv ----
// concurrent checks on the video output block ports
`timescale 1ns/1ps
module vot_video_out_asserts (
  input wire i_ref_clk, // clock
  input wire i_rst, // reset
  input wire [7:0] i_addr, // address
  input wire [31:0] i_wdata, // write data
  input wire i_wr, // write
  input wire i_rd, // read
  input wire [31:0] o_rdata, // read data
  input wire i_video_clk, // video clock
  input wire i_frame_pin_i, // frame in
  input wire o_frame_pin_o, // frame out
  input wire o_frame_pin_oe, // frame enable
  input wire o_line_pin, // line pin
  input wire [7:0] o_byte, // byte bus
  input wire o_msg_done // empty flag
);
  reg [10:0] ctl;
  reg [3:0] quiet;
  reg [3:0] age;
  reg vs;
  reg vq;
  // mode changes settle on a later video edge, so wait them out
  wire calm = quiet == 4'hF;
  wire data_md = ctl[0] && ctl[9:8] != 2'h0 && calm;
  always @(posedge i_ref_clk) begin
    vs <= i_video_clk;
    vq <= vs;
    if (i_rst || (vs && !vq))
      age <= 4'h0;
    else if (age != 4'hF)
      age <= age + 4'h1;
    if (i_rst) begin
      ctl <= 11'h000;
      quiet <= 4'h0;
    end else if (i_wr && i_addr == 8'h00) begin
      ctl <= i_wdata[10:0];
      if (i_wdata[9:0] != ctl[9:0])
        quiet <= 4'h0;
    end else if (!calm)
      quiet <= quiet + 4'h1;
  end
  a_idle_pins: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !ctl[0] && calm |-> o_line_pin && !o_frame_pin_o && o_frame_pin_oe)
    else $error("timing pins active while disabled");
  a_master_drive: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    ctl[0] && ctl[1] && calm |-> o_frame_pin_oe)
    else $error("master not driving frame pin");
  a_slave_release: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    ctl[0] && !ctl[1] && ctl[9:8] == 2'h0 && calm |-> !o_frame_pin_oe)
    else $error("slave drives frame pin");
  a_byte_launch: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    ctl[0] && calm && !$stable(o_byte) |-> age <= 4'h6)
    else $error("byte changed away from video edge");
  a_line_pulse: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    data_md && $rose(o_line_pin) |-> o_line_pin[*8] ##1 !o_line_pin)
    else $error("line pulse not one video clock");
  a_valid_start: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    data_md && ctl[5] && ctl[9:8] == 2'h1 && $rose(o_frame_pin_o)
    |-> $fell(o_line_pin))
    else $error("valid not right after line pulse");
  a_end_pulse: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    data_md && ctl[9:8] == 2'h2 && $rose(o_frame_pin_o)
    |-> o_frame_pin_o[*8] ##1 !o_frame_pin_o)
    else $error("end pulse not one video clock");
  a_end_flag: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    data_md && $rose(o_msg_done) |-> o_frame_pin_o || $past(o_frame_pin_o))
    else $error("empty flag without end pulse");
  a_field_flip: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    ctl[0] && ctl[1] && ctl[9:8] == 2'h0 && calm &&
    $changed(o_frame_pin_o) |-> o_byte == 8'hFF)
    else $error("frame pin moved away from preamble start");
endmodule
bind vot_video_out vot_video_out_asserts chk (.i_ref_clk(i_ref_clk),
  .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .i_video_clk(i_video_clk),
  .i_frame_pin_i(i_frame_pin_i), .o_frame_pin_o(o_frame_pin_o),
  .o_frame_pin_oe(o_frame_pin_oe), .o_line_pin(o_line_pin),
  .o_byte(o_byte), .o_msg_done(o_msg_done));

// ---- vot_far_end.sv ----
// far-end model: video clock, frame strobe source and byte taker
`timescale 1ns/1ps
module vot_far_end (
  input wire [15:0] i_per, // video clocks per frame strobe, 0 none
  input wire i_drv, // block drives frame pin
  input wire i_val, // block frame pin value
  input wire [7:0] i_byte, // byte bus
  output reg o_vclk, // video clock
  output wire o_fpin, // frame pin level
  output reg [7:0] o_last // byte taken at last edge
);
  reg strobe;
  integer n;
  // phase offset keeps video edges off the block clock edges
  initial begin
    o_vclk = 1'b0;
    strobe = 1'b0;
    n = 0;
    o_last = 8'h00;
    #13;
    forever #160 o_vclk = ~o_vclk;
  end
  always @(posedge o_vclk) begin
    o_last <= i_byte;
    n <= (i_per == 16'h0000 || n + 1 >= i_per) ? 0 : n + 1;
    strobe <= i_per != 16'h0000 && n < 4;
  end
  assign o_fpin = i_drv ? i_val : strobe;
endmodule

// ---- tb_top.sv ----
// self-checking testbench for the video output block
`timescale 1ns/1ps
`include "vot_consts.vh"
module tb_top;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg [7:0] addr = 8'h00;
  reg [31:0] wdata = 32'h0;
  reg [15:0] per = 16'h0000;
  wire [31:0] rdata;
  wire vclk, fpin, fo, foe, line, done;
  wire [7:0] byt, last;
  integer bad_count = 0, compares = 0, i, lh, fh;
  reg [31:0] r;
  always #20 clk = ~clk;
  vot_video_out uut (.i_ref_clk(clk), .i_rst(rst), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_video_clk(vclk), .i_frame_pin_i(fpin), .o_frame_pin_o(fo),
    .o_frame_pin_oe(foe), .o_line_pin(line), .o_byte(byt),
    .o_msg_done(done));
  vot_far_end far (.i_per(per), .i_drv(foe), .i_val(fo), .i_byte(byt),
    .o_vclk(vclk), .o_fpin(fpin), .o_last(last));
  task chk(input [31:0] got, input [31:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task wr_reg(input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask
  task rd_reg(input [7:0] a);
    begin
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 r = rdata;
    end
  endtask
  task count_pins(input integer n);
    begin
      lh = 0;
      fh = 0;
      for (i = 0; i < n; i = i + 1) begin
        @(posedge vclk);
        lh = lh + line;
        fh = fh + fo;
      end
    end
  endtask
  task s_reset;
    begin
      rd_reg(`VOT_A_CTL); chk(r, 32'h0);
      rd_reg(`VOT_A_FRAME); chk(r, 32'h0002020D);
      rd_reg(`VOT_A_LINE); chk(r, 32'h011406B4);
      rd_reg(`VOT_A_FIELD); chk(r, 32'h0000010A);
      rd_reg(`VOT_A_LOCK); chk(r, 32'h0);
      rd_reg(8'h30); chk(r, 32'h0);
      chk({line, fo, foe}, 3'b101);
    end
  endtask
  task s_master;
    begin
      wr_reg(`VOT_A_FRAME, 32'h00020004);
      wr_reg(`VOT_A_LINE, 32'h00080010);
      wr_reg(`VOT_A_FIELD, 32'h3);
      wr_reg(`VOT_A_CTL, 32'h13);
      count_pins(16);
      count_pins(64);
      chk(lh, 32);
      chk(fh, 32);
      wr_reg(`VOT_A_CTL, 32'h03);
      count_pins(16);
      count_pins(64);
      chk(fh, 16);
      chk(foe, 1'b1);
      wr_reg(`VOT_A_CTL, 32'h01);
      count_pins(16);
      chk(foe, 1'b0);
    end
  endtask
  task s_lock;
    begin
      wr_reg(`VOT_A_LOCK, 32'd13);
      wr_reg(`VOT_A_CTL, 32'h0D);
      per <= 16'd64;
      repeat (256) @(posedge vclk);
      chk(foe, 1'b0);
      rd_reg(`VOT_A_STAT); chk(r[4], 1'b1);
      wr_reg(`VOT_A_STAT, 32'h4);
      repeat (128) @(posedge vclk);
      rd_reg(`VOT_A_STAT); chk(r[2], 1'b0);
      // one more delay cycle moves the realign point by one video clock
      wr_reg(`VOT_A_LOCK, 32'd14);
      repeat (128) @(posedge vclk);
      rd_reg(`VOT_A_STAT); chk(r[2], 1'b1);
      wr_reg(`VOT_A_STAT, 32'h4);
      // falling edge is four video clocks after the rising one
      wr_reg(`VOT_A_CTL, 32'h05);
      repeat (128) @(posedge vclk);
      rd_reg(`VOT_A_STAT); chk(r[2], 1'b1);
      wr_reg(`VOT_A_STAT, 32'h4);
      repeat (128) @(posedge vclk);
      rd_reg(`VOT_A_STAT); chk(r[2], 1'b0);
      per <= 16'd60;
      repeat (192) @(posedge vclk);
      rd_reg(`VOT_A_STAT); chk(r[2], 1'b1);
      per <= 16'h0000;
    end
  endtask
  task s_stream;
    begin
      wr_reg(`VOT_A_CTL, 32'h121);
      wr_reg(`VOT_A_DATA, 32'hA5);
      repeat (20) @(posedge clk);
      wr_reg(`VOT_A_CTL, 32'h521);
      for (i = 0; i < 100 && fo !== 1'b1; i = i + 1) @(posedge clk);
      chk(byt, 8'hA5);
      wr_reg(`VOT_A_DATA, 32'h3C);
      for (i = 0; i < 20 && byt !== 8'h3C; i = i + 1) @(posedge clk);
      chk(fo, 1'b1);
      for (i = 0; i < 40 && fo !== 1'b0; i = i + 1) @(posedge clk);
      chk(last, 8'h3C);
      rd_reg(`VOT_A_STAT); chk(r[1], 1'b1);
    end
  endtask
  task s_msg;
    begin
      wr_reg(`VOT_A_MLEN, 32'h3);
      wr_reg(`VOT_A_MSG, 32'h11);
      wr_reg(`VOT_A_MSG, 32'h22);
      wr_reg(`VOT_A_MSG, 32'h33);
      wr_reg(`VOT_A_CTL, 32'h201);
      repeat (20) @(posedge clk);
      wr_reg(`VOT_A_CTL, 32'h601);
      for (i = 0; i < 40 && line !== 1'b1; i = i + 1) @(posedge clk);
      chk(line, 1'b1);
      for (i = 0; i < 60 && byt !== 8'h11; i = i + 1) @(posedge clk);
      for (i = 0; i < 12 && byt !== 8'h22; i = i + 1) @(posedge clk);
      for (i = 0; i < 12 && byt !== 8'h33; i = i + 1) @(posedge clk);
      chk(byt, 8'h33);
      for (i = 0; i < 30 && done !== 1'b1; i = i + 1) @(posedge clk);
      chk(done, 1'b1);
      rd_reg(`VOT_A_CTL); chk(r[10], 1'b0);
      rd_reg(`VOT_A_STAT); chk(r[0], 1'b1);
    end
  endtask
  task s_img;
    begin
      wr_reg(`VOT_A_IMG, 32'h00040008);
      rd_reg(`VOT_A_CSIZE); chk(r, 32'd16);
      wr_reg(`VOT_A_IMG, 32'h10040008);
      rd_reg(`VOT_A_CSIZE); chk(r, 32'd8);
      wr_reg(`VOT_A_OVW, 32'hC);
      // two bytes per overlay pixel, so 12 pixels make 24 bytes
      rd_reg(`VOT_A_OVW); chk(r, 32'd24);
    end
  endtask
  task print_verdict;
    begin
      if (bad_count == 0 && compares > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    s_reset;
    s_master;
    s_lock;
    s_stream;
    s_msg;
    s_img;
    print_verdict;
  end
  initial begin
    #2000000;
    bad_count = bad_count + 1;
    print_verdict;
  end
endmodule
